// file: design/rms_pkg.sv
// Package of constants and types for the redundant master selector
package rms_pkg;

    // Mode key switch positions
    typedef enum logic [1:0] {
        RMS_MODE_AUTO   = 2'h0,
        RMS_MODE_FORCEA = 2'h1,
        RMS_MODE_FORCEB = 2'h2
    } rms_mode_t;

    // Selector states
    typedef enum logic [2:0] {
        RMS_ST_POWERUP = 3'h0,
        RMS_ST_ON_A    = 3'h1,
        RMS_ST_ON_B    = 3'h2,
        RMS_ST_NONE    = 3'h3
    } rms_state_t;

    // Register byte offsets
    localparam logic [3:0] RMS_OFS_CTRL   = 4'h0;
    localparam logic [3:0] RMS_OFS_STATUS = 4'h4;
    localparam logic [3:0] RMS_OFS_IRQ    = 4'h8;
    localparam logic [3:0] RMS_OFS_MASK   = 4'hc;

    // Field positions
    localparam int RMS_CTRL_REQ_A   = 0;
    localparam int RMS_CTRL_REQ_B   = 1;
    localparam int RMS_IRQ_SWITCH   = 0;
    localparam int RMS_IRQ_PWRFAIL  = 1;
    localparam int RMS_IRQ_NOSTBY   = 2;
    localparam int RMS_IRQ_W        = 3;

    // Reset values
    localparam logic [2:0] RMS_MASK_RST = 3'h0;
    localparam logic [2:0] RMS_IRQ_RST  = 3'h0;

    // AXI responses
    localparam logic [1:0] RMS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] RMS_RESP_SLVERR = 2'h2;

    // Settle time of inputs after power-up
    localparam int RMS_CLK_MHZ     = 40;
    localparam int RMS_SETTLE_US   = 10;
    localparam int RMS_SETTLE_CYC  = RMS_SETTLE_US * RMS_CLK_MHZ;
    localparam int RMS_SETTLE_W    = 9;

endpackage

// file: design/rms_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module rms_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,   // System clock
    input  wire logic         i_nrst,  // Async reset, active low
    input  wire logic         i_ce,    // Clock enable
    input  wire logic [W-1:0] i_d,     // Asynchronous inputs
    output var  logic [W-1:0] o_q      // Synchronised outputs
);

    logic [W-1:0] meta;

    // ------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            // Two flops per bit
            always_ff @(posedge i_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                begin
                    meta[g] <= 1'b0;
                    o_q[g]  <= 1'b0;
                end
                else if (i_ce)
                begin
                    meta[g] <= i_d[g];
                    o_q[g]  <= meta[g];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// file: design/rms_selector.sv
// Redundant master selector with AXI4-Lite registers
// What this block does
// - Watch both watchdog-bad inputs and combine with switches to choose primary.
// - Drive unit control output only to the selected master controller.
// - Mode key switch: force A, force B, or automatic selection.
// - Forced setting puts that controller on-line even if its watchdog failed.
// - Primary select toggle honoured only at power-up in automatic mode.
// - Power-up auto: preferred if ready, else alternate if healthy.
// - Software request moves on-line duty from primary to standby.
// - Status relay energized while power healthy, released on power failure.
// - Requested fail-over only with valid standby and automatic mode.
// - Forcing the standby controller makes it the new primary.
`timescale 1ns/1ps
`default_nettype none

module rms_selector (
    input  wire logic        i_clk,          // 40 MHz clock
    input  wire logic        i_nrst,         // Async reset, active low
    input  wire logic        i_ce,           // Clock enable
    // Pins
    input  wire logic        i_wdog_bad_a,   // Controller A watchdog bad
    input  wire logic        i_wdog_bad_b,   // Controller B watchdog bad
    input  wire logic [1:0]  i_mode_key,     // Mode key switch position
    input  wire logic        i_prim_sel_b,   // Toggle: 1 prefers B
    input  wire logic        i_power_ok,     // Power system healthy
    output var  logic        o_unit_ctrl_a,  // Unit control to A
    output var  logic        o_unit_ctrl_b,  // Unit control to B
    output var  logic        o_relay_on,     // Status relay coil
    output logic             o_irq,          // Interrupt, level
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,   // Write address
    input  wire logic        s_axi_awvalid,  // Write address valid
    output logic             s_axi_awready,  // Write address ready
    input  wire logic [31:0] s_axi_wdata,    // Write data
    input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
    input  wire logic        s_axi_wvalid,   // Write data valid
    output logic             s_axi_wready,   // Write data ready
    output var  logic [1:0]  s_axi_bresp,    // Write response
    output var  logic        s_axi_bvalid,   // Write response valid
    input  wire logic        s_axi_bready,   // Write response ready
    input  wire logic [3:0]  s_axi_araddr,   // Read address
    input  wire logic        s_axi_arvalid,  // Read address valid
    output logic             s_axi_arready,  // Read address ready
    output var  logic [31:0] s_axi_rdata,    // Read data
    output var  logic [1:0]  s_axi_rresp,    // Read response
    output var  logic        s_axi_rvalid,   // Read response valid
    input  wire logic        s_axi_rready    // Read response ready
);

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [5:0] pins_s;
    logic       bad_a;
    logic       bad_b;
    logic [1:0] mode;
    logic       pref_b;
    logic       pwr_ok;

    rms_sync #(.W(6)) u_sync (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_ce   (i_ce),
        .i_d    ({i_power_ok, i_prim_sel_b, i_mode_key,
                  i_wdog_bad_b, i_wdog_bad_a}),
        .o_q    (pins_s)
    );

    // Synchronised pin fields
    assign bad_a  = pins_s[0];
    assign bad_b  = pins_s[1];
    assign mode   = pins_s[3:2];
    assign pref_b = pins_s[4];
    assign pwr_ok = pins_s[5];

    logic [rms_pkg::RMS_SETTLE_W-1:0] settle_cnt;
    logic                             settled;

    // Wait for synchronisers and switches to settle
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            settle_cnt <= '0;
        else if (i_ce && !settled)
            settle_cnt <= settle_cnt + 1'b1;
    end

    assign settled = (settle_cnt ==
        rms_pkg::RMS_SETTLE_W'(rms_pkg::RMS_SETTLE_CYC - 1));

    // ------------------------------------------------------------
    // Software fail-over request
    // ------------------------------------------------------------
    logic       req_set;
    logic       req_pend;
    logic       fo_taken;
    logic       fo_drop;
    logic       ctrl_wr;
    logic [31:0] wdata_q;

    // Pending request: set wins over clear
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            req_pend <= 1'b0;
        else if (i_ce)
        begin
            if (req_set)
                req_pend <= 1'b1;
            else if (fo_taken || fo_drop)
                req_pend <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Selector state machine
    // ------------------------------------------------------------
    rms_pkg::rms_state_t state;
    rms_pkg::rms_state_t next_state;
    logic                auto_mode;
    logic                sw_event;

    assign auto_mode = (mode == rms_pkg::RMS_MODE_AUTO);

    // Next primary from watchdogs, switches and requests
    always_comb
    begin
        next_state = state;
        fo_taken   = 1'b0;
        fo_drop    = 1'b0;
        case (state)
            rms_pkg::RMS_ST_POWERUP:
            begin
                if (settled)
                begin
                    if (mode == rms_pkg::RMS_MODE_FORCEA)
                        next_state = rms_pkg::RMS_ST_ON_A;
                    else if (mode == rms_pkg::RMS_MODE_FORCEB)
                        next_state = rms_pkg::RMS_ST_ON_B;
                    else if (!pref_b && !bad_a)
                        next_state = rms_pkg::RMS_ST_ON_A;
                    else if (pref_b && !bad_b)
                        next_state = rms_pkg::RMS_ST_ON_B;
                    else if (!bad_a)
                        next_state = rms_pkg::RMS_ST_ON_A;
                    else if (!bad_b)
                        next_state = rms_pkg::RMS_ST_ON_B;
                    else
                        next_state = rms_pkg::RMS_ST_NONE;
                end
            end
            rms_pkg::RMS_ST_ON_A:
            begin
                if (mode == rms_pkg::RMS_MODE_FORCEB)
                    next_state = rms_pkg::RMS_ST_ON_B;
                else if (auto_mode && !bad_b && (bad_a || req_pend))
                begin
                    next_state = rms_pkg::RMS_ST_ON_B;
                    fo_taken   = req_pend;
                end
                else if (req_pend)
                    fo_drop = 1'b1;
            end
            rms_pkg::RMS_ST_ON_B:
            begin
                if (mode == rms_pkg::RMS_MODE_FORCEA)
                    next_state = rms_pkg::RMS_ST_ON_A;
                else if (auto_mode && !bad_a && (bad_b || req_pend))
                begin
                    next_state = rms_pkg::RMS_ST_ON_A;
                    fo_taken   = req_pend;
                end
                else if (req_pend)
                    fo_drop = 1'b1;
            end
            rms_pkg::RMS_ST_NONE:
            begin
                fo_drop = req_pend;
                if (mode == rms_pkg::RMS_MODE_FORCEB ||
                    (mode != rms_pkg::RMS_MODE_FORCEA && bad_a && !bad_b))
                    next_state = rms_pkg::RMS_ST_ON_B;
                else if (mode == rms_pkg::RMS_MODE_FORCEA || !bad_a)
                    next_state = rms_pkg::RMS_ST_ON_A;
            end
            default:
                next_state = rms_pkg::RMS_ST_POWERUP;
        endcase
    end

    // State register
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            state <= rms_pkg::RMS_ST_POWERUP;
        else if (i_ce)
            state <= next_state;
    end

    // A change of primary after power-up
    assign sw_event = i_ce && (state != next_state) &&
                      (state != rms_pkg::RMS_ST_POWERUP);

    // Unit control only to the master, relay follows power
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_unit_ctrl_a <= 1'b0;
            o_unit_ctrl_b <= 1'b0;
            o_relay_on    <= 1'b0;
        end
        else if (i_ce)
        begin
            o_unit_ctrl_a <= (next_state == rms_pkg::RMS_ST_ON_A);
            o_unit_ctrl_b <= (next_state == rms_pkg::RMS_ST_ON_B);
            o_relay_on    <= pwr_ok;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    logic [rms_pkg::RMS_IRQ_W-1:0] irq_stat;
    logic [rms_pkg::RMS_IRQ_W-1:0] irq_mask;
    logic [rms_pkg::RMS_IRQ_W-1:0] irq_set;
    logic [rms_pkg::RMS_IRQ_W-1:0] irq_clr;
    logic                          pwr_q;
    logic                          stat_wr;
    logic                          mask_wr;

    // Previous power level for fall detection
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            pwr_q <= 1'b0;
        else if (i_ce)
            pwr_q <= pwr_ok;
    end

    assign irq_set[rms_pkg::RMS_IRQ_SWITCH]  = sw_event;
    assign irq_set[rms_pkg::RMS_IRQ_PWRFAIL] = i_ce && pwr_q && !pwr_ok;
    assign irq_set[rms_pkg::RMS_IRQ_NOSTBY]  = i_ce && fo_drop;
    assign irq_clr = stat_wr ? wdata_q[rms_pkg::RMS_IRQ_W-1:0] : '0;

    // Sticky bits, set wins over write-one clear
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            irq_stat <= rms_pkg::RMS_IRQ_RST;
        else if (i_ce)
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end

    // Mask register
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            irq_mask <= rms_pkg::RMS_MASK_RST;
        else if (i_ce && mask_wr)
            irq_mask <= wdata_q[rms_pkg::RMS_IRQ_W-1:0];
    end

    assign o_irq = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic        aw_got;
    logic        w_got;
    logic [3:0]  awaddr_q;
    logic        wr_go;

    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready  = !w_got && !s_axi_bvalid;
    assign wr_go = i_ce && aw_got && w_got && !s_axi_bvalid;
    assign ctrl_wr = wr_go && (awaddr_q == rms_pkg::RMS_OFS_CTRL);
    assign stat_wr = wr_go && (awaddr_q == rms_pkg::RMS_OFS_IRQ);
    assign mask_wr = wr_go && (awaddr_q == rms_pkg::RMS_OFS_MASK);
    // Request applies to the controller named as current primary
    assign req_set = ctrl_wr &&
        ((wdata_q[rms_pkg::RMS_CTRL_REQ_A] &&
          state == rms_pkg::RMS_ST_ON_A) ||
         (wdata_q[rms_pkg::RMS_CTRL_REQ_B] &&
          state == rms_pkg::RMS_ST_ON_B));

    // Capture address and data in either order, then respond
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            awaddr_q     <= '0;
            wdata_q      <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= rms_pkg::RMS_RESP_OKAY;
        end
        else if (i_ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got   <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got   <= 1'b1;
                wdata_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
            end
            if (wr_go)
            begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_q == rms_pkg::RMS_OFS_STATUS) ?
                    rms_pkg::RMS_RESP_SLVERR : rms_pkg::RMS_RESP_OKAY;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    // Read mux, answer one cycle after address
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= rms_pkg::RMS_RESP_OKAY;
        end
        else if (i_ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= rms_pkg::RMS_RESP_OKAY;
                case (s_axi_araddr)
                    rms_pkg::RMS_OFS_CTRL:
                        s_axi_rdata <= {31'h0, req_pend};
                    rms_pkg::RMS_OFS_STATUS:
                        s_axi_rdata <= {21'h0, state, pwr_ok, pref_b, mode,
                            bad_b, bad_a, o_unit_ctrl_b, o_unit_ctrl_a};
                    rms_pkg::RMS_OFS_IRQ:
                        s_axi_rdata <= {29'h0, irq_stat};
                    rms_pkg::RMS_OFS_MASK:
                        s_axi_rdata <= {29'h0, irq_mask};
                    default:
                    begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= rms_pkg::RMS_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// file: testbench/rms_ctl_model.sv
// Behavioural model of the two redundant controllers
`timescale 1ns/1ps
`default_nettype none

module rms_ctl_model (
    input  wire logic i_clk,        // Clock
    input  wire logic i_fail_a,     // Program fault on A
    input  wire logic i_fail_b,     // Program fault on B
    output var  logic o_wdog_bad_a, // Watchdog bad A
    output var  logic o_wdog_bad_b  // Watchdog bad B
);
    // Watchdog hardware flags a misbehaving program
    always_ff @(posedge i_clk)
    begin
        o_wdog_bad_a <= i_fail_a;
        o_wdog_bad_b <= i_fail_b;
    end
endmodule
`default_nettype wire

// file: testbench/rms_selector_chk.sv
// Assertion checker for the redundant master selector
`timescale 1ns/1ps
`default_nettype none

module rms_selector_chk (
    input wire logic       i_clk,         // Clock
    input wire logic       i_nrst,        // Reset
    input wire logic       i_wdog_bad_a,  // Bad A
    input wire logic       i_wdog_bad_b,  // Bad B
    input wire logic [1:0] i_mode_key,    // Key
    input wire logic       i_prim_sel_b,  // Toggle
    input wire logic       i_power_ok,    // Power
    input wire logic       o_unit_ctrl_a, // Unit A
    input wire logic       o_unit_ctrl_b, // Unit B
    input wire logic       o_relay_on,    // Relay
    input wire logic       s_axi_arvalid, // Ar valid
    input wire logic       s_axi_arready, // Ar ready
    input wire logic       s_axi_rvalid   // R valid
);
    logic [9:0] up_cnt;

    // Cycles since reset release, saturating
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            up_cnt <= 10'h000;
        else if (up_cnt != 10'h3ff)
            up_cnt <= up_cnt + 10'h001;
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_EXCL: assert property (
        !(o_unit_ctrl_a && o_unit_ctrl_b))
        else $error("both unit controls high");
    AST_SETTLE: assert property (
        up_cnt < 10'h18b |-> !o_unit_ctrl_a && !o_unit_ctrl_b)
        else $error("unit control before settle");
    AST_PWRUP: assert property (
        up_cnt == 10'h19a && i_mode_key == 2'h0
        && !(i_wdog_bad_a && i_wdog_bad_b)
        |-> o_unit_ctrl_a != o_unit_ctrl_b && o_unit_ctrl_b ==
            (i_wdog_bad_a || (i_prim_sel_b && !i_wdog_bad_b)))
        else $error("wrong primary at power-up");
    AST_FORCE_A: assert property (
        (up_cnt > 10'h19a && i_mode_key == 2'h1) [*8] |-> o_unit_ctrl_a)
        else $error("forced A not on-line");
    AST_FORCE_B: assert property (
        (up_cnt > 10'h19a && i_mode_key == 2'h2) [*8] |-> o_unit_ctrl_b)
        else $error("forced B not on-line");
    AST_WDOG: assert property (
        o_unit_ctrl_a && i_mode_key == 2'h0 ##1
        (i_wdog_bad_a && !i_wdog_bad_b && i_mode_key == 2'h0) [*8]
        |-> o_unit_ctrl_b)
        else $error("no move away from failed primary");
    AST_RELAY_ON: assert property (
        i_power_ok [*5] |=> o_relay_on)
        else $error("relay not energized");
    AST_RELAY_OFF: assert property (
        !i_power_ok [*5] |=> !o_relay_on)
        else $error("relay not released");
    AST_RD_LAT: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");

    // Main scenarios reached
    COV_MOVE_B: cover property ($rose(o_unit_ctrl_b));
    COV_PWR_FAIL: cover property ($fell(o_relay_on));
    COV_FORCE_BAD: cover property (
        i_mode_key == 2'h2 && i_wdog_bad_b && o_unit_ctrl_b);
endmodule

bind rms_selector rms_selector_chk chk (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_wdog_bad_a(i_wdog_bad_a), .i_wdog_bad_b(i_wdog_bad_b),
    .i_mode_key(i_mode_key), .i_prim_sel_b(i_prim_sel_b),
    .i_power_ok(i_power_ok), .o_unit_ctrl_a(o_unit_ctrl_a),
    .o_unit_ctrl_b(o_unit_ctrl_b), .o_relay_on(o_relay_on),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

// file: testbench/tb_redundant_master_selector.sv
// Self-checking testbench for the redundant master selector
`timescale 1ns/1ps
`default_nettype none

module tb_redundant_master_selector;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [1:0]  key = 2'h0;
    logic        pref_b = 1'b0;
    logic        pwr_ok = 1'b1;
    logic        fail_a = 1'b0;
    logic        fail_b = 1'b0;
    logic        bad_a, bad_b, ua, ub, relay, irq;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] rdata, rd;
    logic [3:0]  awaddr = 4'h0;
    logic [3:0]  araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    int          bad_count = 0;
    int          n_compared = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    rms_selector dut (.i_clk(clk), .i_nrst(nrst), .i_ce(1'b1),
        .i_wdog_bad_a(bad_a), .i_wdog_bad_b(bad_b), .i_mode_key(key),
        .i_prim_sel_b(pref_b), .i_power_ok(pwr_ok),
        .o_unit_ctrl_a(ua), .o_unit_ctrl_b(ub), .o_relay_on(relay),
        .o_irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    rms_ctl_model ctl (.i_clk(clk), .i_fail_a(fail_a), .i_fail_b(fail_b),
        .o_wdog_bad_a(bad_a), .o_wdog_bad_b(bad_b));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic stop_test;
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One edge of a bounded wait
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 200)
        begin
            bad_count++;
            $display("Error at %0t: timeout", $time);
            stop_test();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wait_unit(input logic a, input logic b);
        int n;
        n = 0;
        while ({ua, ub} !== {a, b})
            tick(n);
    endtask

    // Bus write: address and data offered together
    task automatic axw(input logic [3:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            tick(n);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [3:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            tick(n);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Power-up with given switches and controller health
    task automatic pwrup(input logic [1:0] k, input logic p,
                         input logic fa, input logic fb);
        nrst <= 1'b0;
        key <= k;
        pref_b <= p;
        fail_a <= fa;
        fail_b <= fb;
        cyc(16);
        nrst <= 1'b1;
        cyc(430);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_pwrup;
        logic [6:0] tab [7] = '{7'h02, 7'h11, 7'h09, 7'h16, 7'h3a,
                                7'h45, 7'h0c};
        foreach (tab[i])
        begin
            pwrup(tab[i][6:5], tab[i][4], tab[i][3], tab[i][2]);
            check(32'({ua, ub}), 32'(tab[i][1:0]));
            axr(rms_pkg::RMS_OFS_STATUS, rd, rs);
            check(rd & 32'hff, 32'({pwr_ok, pref_b, key, fail_b, fail_a,
                  tab[i][0], tab[i][1]}));
            pref_b <= ~pref_b;
            cyc(20);
            check(32'({ua, ub}), 32'(tab[i][1:0]));
        end
    endtask

    task automatic s_wdog;
        pwrup(2'h0, 1'b0, 1'b0, 1'b0);
        fail_a <= 1'b1;
        wait_unit(1'b0, 1'b1);
        check(32'({ua, ub}), 32'h1);
        fail_a <= 1'b0;
        cyc(20);
        check(32'({ua, ub}), 32'h1);
        fail_b <= 1'b1;
        wait_unit(1'b1, 1'b0);
        check(32'({ua, ub}), 32'h2);
        fail_b <= 1'b0;
    endtask

    task automatic s_force;
        pwrup(2'h0, 1'b0, 1'b0, 1'b1);
        key <= 2'h2;
        wait_unit(1'b0, 1'b1);
        check(32'({ua, ub}), 32'h1);
        key <= 2'h1;
        fail_b <= 1'b0;
        wait_unit(1'b1, 1'b0);
        check(32'({ua, ub}), 32'h2);
        axw(rms_pkg::RMS_OFS_CTRL, 32'h1, rs);
        cyc(20);
        check(32'({ua, ub}), 32'h2);
        axr(rms_pkg::RMS_OFS_IRQ, rd, rs);
        check(rd & 32'h4, 32'h4);
    endtask

    task automatic s_req;
        pwrup(2'h0, 1'b0, 1'b0, 1'b0);
        axw(rms_pkg::RMS_OFS_CTRL, 32'h1, rs);
        wait_unit(1'b0, 1'b1);
        check(32'({ua, ub}), 32'h1);
        axw(rms_pkg::RMS_OFS_IRQ, 32'h7, rs);
        fail_a <= 1'b1;
        cyc(10);
        axw(rms_pkg::RMS_OFS_CTRL, 32'h2, rs);
        cyc(20);
        check(32'({ua, ub}), 32'h1);
        axr(rms_pkg::RMS_OFS_IRQ, rd, rs);
        check(rd, 32'h4);
        check(32'(irq), 32'h0);
        axw(rms_pkg::RMS_OFS_MASK, 32'h4, rs);
        cyc(2);
        check(32'(irq), 32'h1);
        axw(rms_pkg::RMS_OFS_IRQ, 32'h4, rs);
        cyc(2);
        check(32'(irq), 32'h0);
        fail_a <= 1'b0;
    endtask

    task automatic s_pwr;
        check(32'(relay), 32'h1);
        pwr_ok <= 1'b0;
        cyc(8);
        check(32'(relay), 32'h0);
        axr(rms_pkg::RMS_OFS_IRQ, rd, rs);
        check(rd & 32'h2, 32'h2);
        pwr_ok <= 1'b1;
        cyc(8);
        check(32'(relay), 32'h1);
    endtask

    task automatic s_bus;
        axw(rms_pkg::RMS_OFS_STATUS, 32'hff, rs);
        check(32'(rs), 32'(rms_pkg::RMS_RESP_SLVERR));
        axr(4'h2, rd, rs);
        check(32'(rs), 32'(rms_pkg::RMS_RESP_SLVERR));
        check(rd, 32'h0);
        axr(rms_pkg::RMS_OFS_MASK, rd, rs);
        check(rd, 32'h4);
        check(32'(rs), 32'(rms_pkg::RMS_RESP_OKAY));
    endtask

    // Main sequence
    initial
    begin
        s_pwrup();
        s_wdog();
        s_force();
        s_req();
        s_pwr();
        s_bus();
        stop_test();
    end
endmodule
`default_nettype wire
